// ### inc/rws_pkg.sv
// constants, types and register map of the reset and wake sequencer
package rws_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RTC_HZ = 32768;
  localparam int RTC_DIV_DEF = CLK_HZ / RTC_HZ;
  localparam int CORE_DIV_DEF = 2;
  localparam int CONV_MS = 350;
  localparam int PLL_MS = 16;
  localparam int COLD_MS = 2;
  localparam int BOOT_S = 4;
  // least times, rounded up to whole rtc ticks
  localparam int CONV_TICKS = (CONV_MS * RTC_HZ + 999) / 1000;
  localparam int PLL_TICKS = (PLL_MS * RTC_HZ + 999) / 1000;
  localparam int COLD_TICKS = (COLD_MS * RTC_HZ + 999) / 1000;
  localparam int BOOT_TICKS = BOOT_S * RTC_HZ;
  localparam int CHECK_TICKS = 3;
  localparam int FAIL_TICKS = 1;
  localparam int PASS_TICKS = 3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDOG = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_RTC = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_CSTAT = 8'h14;
  localparam logic [7:0] ADDR_CCFG = 8'h18;
  localparam logic [7:0] ADDR_SEQ = 8'h1C;
  localparam int CTRL_BOOT_CLR = 0;
  localparam int CTRL_WD_EN = 1;
  localparam int CTRL_WD_CLR = 2;
  localparam int CAUSE_RTC = 0;
  localparam int CAUSE_SWITCH = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_SLEEP = 3;
  localparam int CAUSE_BOOT = 4;
  localparam logic [31:0] WDOG_PERIOD_RST = 32'h0000_8000;
  localparam int ST_ERL_BIT = 2;
  localparam int ST_SR_BIT = 20;
  localparam int ST_TS_BIT = 21;
  localparam int ST_BEV_BIT = 22;
  localparam logic [3:0] CFG_HI_INIT = 4'h0;
  localparam logic [19:0] CFG_MID_INIT = 20'h04800;
  localparam logic [4:0] RANDOM_INIT = 5'h1F;
  localparam logic [4:0] WIRED_INIT = 5'h00;
  // synchronised pins: rtc_n, push_n, power, card_n, battery, gpio[7:0]
  localparam logic [12:0] PIN_RST = 13'h0A00;
  typedef enum logic [1:0] {PM_FULL, PM_STANDBY, PM_SUSPEND, PM_HIBERNATE} rws_pmode_t;
  typedef struct packed {
    logic [4:0] random_index;
    logic [4:0] wired_count;
  } rws_tlb_init_t;
  typedef struct packed {
    logic power_button;
    logic card_detect;
    logic alarm;
    logic gpio;
  } rws_wake_t;
endpackage

// ### logic/rws_sequencer.sv
// reset and wake sequencer with classic wishbone register slave
//
// Function
// - rtc counter starts counting once rtc init is released.
// - battery ok raises main supply, waits 350 ms, starts pll, 16 ms later clocks.
// - rtc init clears all state, no status kept, dram not in self refresh.
// - push switch pulses 100 us; on release pll restarts at once, clocks 16 ms later.
// - switch, watchdog, sleep, boot timer resets keep rtc counter and power unit.
// - enabled watchdog not cleared within its period resets the core at once.
// - deep sleep puts dram in self refresh, drops main supply, enters reset.
// - boot timer not cleared within four seconds of rtc release forces reset.
// - wake on power button, card detect, alarm timer or gpio inputs.
// - wake raises supply request; battery inhibit sampled three rtc ticks later.
// - battery low drops supply request one tick after check, no activation.
// - battery high raises main supply at check, drops supply request three ticks later.
// - every listed reset source performs a core cold reset.
// - cold reset clears tlb and soft flags, sets error and boot flags, tlb values.
// - cold reset clears config 31..28 and loads 0x04800 into config 22..3.
// - cold init and core init assert, 2 ms later release in turn on core clock.
// - core owns the system bus in reset and fetches the reset vector after it.
// - after any reset the core is bus master and starts the cold sequence.
// - logic only soft reset is not provided.
// - core mode updates on status or config writes, unit mode on its register.
// - four power modes: full speed, standby, suspend, hibernate.
// - every reset returns the power mode to full speed.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module rws_sequencer #(
  parameter int RTC_DIV = rws_pkg::RTC_DIV_DEF,
  parameter int CORE_DIV = rws_pkg::CORE_DIV_DEF,
  parameter int CONV_T = rws_pkg::CONV_TICKS,
  parameter int PLL_T = rws_pkg::PLL_TICKS,
  parameter int COLD_T = rws_pkg::COLD_TICKS,
  parameter int BOOT_T = rws_pkg::BOOT_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rtc_domain_init_n_i,
  input wire logic push_switch_init_n_i,
  input wire logic power_button_i,
  input wire logic card_detect_n_i,
  input wire logic [7:0] gpio_wake_i,
  input wire logic battery_inhibit_in_i,
  input wire logic alarm_wake_timer_i,
  output logic supply_request_o,
  output logic main_supply_enable_o,
  output logic pll_enable_o,
  output logic clocks_run_o,
  output logic dram_self_refresh_o,
  output logic core_clock_out_o,
  output logic cold_init_n_o,
  output logic core_init_n_o,
  output logic core_bus_owner_o,
  output logic reset_vector_fetch_o,
  output logic core_mode_update_o,
  output rws_pkg::rws_pmode_t power_mode_o,
  output rws_pkg::rws_tlb_init_t tlb_init_o
);
  import rws_pkg::*;

  if (RTC_DIV < 2 || CORE_DIV < 2 || CONV_T < 1 || PLL_T < 1 || COLD_T < 1 || BOOT_T < 1)
  begin : g_bad_param
    $error("rws_sequencer: counts must be at least one, dividers at least two");
  end

  typedef enum logic [3:0] {S_RTC_HOLD, S_OFF, S_WAKE, S_FAIL, S_PASS, S_CONV, S_PLL,
                            S_COLD, S_CORE, S_RUN, S_SWITCH} rws_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once the second and third stage agree
  logic [12:0] pin_raw;
  logic [12:0] pin_s1_r;
  logic [12:0] pin_s2_r;
  logic [12:0] pin_s3_r;
  logic [12:0] pin_f_r;
  assign pin_raw = {rtc_domain_init_n_i, push_switch_init_n_i, power_button_i,
                    card_detect_n_i, battery_inhibit_in_i, gpio_wake_i};
  for (genvar i = 0; i < 13; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_s1_r[i] <= PIN_RST[i];
        pin_s2_r[i] <= PIN_RST[i];
        pin_s3_r[i] <= PIN_RST[i];
        pin_f_r[i] <= PIN_RST[i];
      end else begin
        pin_s1_r[i] <= pin_raw[i];
        pin_s2_r[i] <= pin_s1_r[i];
        pin_s3_r[i] <= pin_s2_r[i];
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_f_r[i] <= pin_s3_r[i];
        end
      end
    end
  end
  logic rtc_n;
  logic push_n;
  logic battery_ok;
  rws_wake_t wake_in;
  assign rtc_n = pin_f_r[12];
  assign push_n = pin_f_r[11];
  assign battery_ok = pin_f_r[8];
  assign wake_in = '{power_button: pin_f_r[10], card_detect: ~pin_f_r[9],
                     alarm: alarm_wake_timer_i, gpio: |pin_f_r[7:0]};

  //////////////////////////////////////////////////////////////////////////////
  // rtc tick; an approximation of 32.768 kHz from the system clock
  logic [31:0] pre_r;
  logic tick;
  logic rtc_clr;
  assign tick = (pre_r == 32'(RTC_DIV - 1));
  assign rtc_clr = rst_i | ~rtc_n;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_r <= 32'h0000_0000;
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
    end
  end

  logic [31:0] rtc_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rtc_clr) begin
      rtc_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      rtc_cnt_r <= rtc_cnt_r + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave, ack one cycle after the request, unmapped reads give zero
  logic req;
  logic wr;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic wr_ctrl;
  logic wr_mode;
  logic wr_core;
  assign wr_ctrl = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];
  assign wr_mode = wr & (wb_adr_i == ADDR_MODE) & wb_sel_i[0];
  assign wr_core = wr & ((wb_adr_i == ADDR_CSTAT) | (wb_adr_i == ADDR_CCFG));

  //////////////////////////////////////////////////////////////////////////////
  // sequence state and events
  rws_state_t state_r;
  rws_state_t state_nxt;
  logic [31:0] seq_cnt_r;
  logic [3:0] wake_mask_r;
  logic sys_clr;
  logic core_edge;
  logic wd_exp;
  logic boot_exp_r;
  logic sleep_req;
  logic wake;
  logic powered;
  // every core reset is a cold one; there is no logic-only reset path
  assign sys_clr = rtc_clr | ~cold_init_n_o;
  assign sleep_req = wr_mode & (rws_pmode_t'(wb_dat_i[1:0]) == PM_HIBERNATE);
  assign wake = |(wake_in & wake_mask_r);
  assign powered = (state_r == S_COLD) | (state_r == S_CORE) | (state_r == S_RUN);

  function automatic logic done(input logic [31:0] cnt, input int n, input logic t);
    return t && (cnt == 32'(n - 1));
  endfunction

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_RTC_HOLD: if (rtc_n) state_nxt = S_OFF;
      S_OFF: if (wake) state_nxt = S_WAKE;
      S_WAKE: begin
        if (done(seq_cnt_r, CHECK_TICKS, tick)) begin
          state_nxt = battery_ok ? S_PASS : S_FAIL;
        end
      end
      S_FAIL: if (done(seq_cnt_r, FAIL_TICKS, tick)) state_nxt = S_OFF;
      S_PASS: if (done(seq_cnt_r, PASS_TICKS, tick)) state_nxt = S_CONV;
      S_CONV: if (done(seq_cnt_r, CONV_T, tick)) state_nxt = S_PLL;
      S_PLL: if (done(seq_cnt_r, PLL_T, tick)) state_nxt = S_COLD;
      S_COLD: if (seq_cnt_r >= 32'(COLD_T) && core_edge) state_nxt = S_CORE;
      S_CORE: if (core_edge) state_nxt = S_RUN;
      S_RUN: state_nxt = S_RUN;
      S_SWITCH: if (push_n) state_nxt = S_PLL;
    endcase
    if (powered) begin
      if (boot_exp_r || sleep_req) begin
        state_nxt = S_OFF;
      end else if (wd_exp) begin
        state_nxt = S_COLD;
      end
    end
    if (!push_n && state_r != S_RTC_HOLD) begin
      state_nxt = S_SWITCH;
    end
    if (!rtc_n) begin
      state_nxt = S_RTC_HOLD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_RTC_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_nxt != state_r) begin
      seq_cnt_r <= 32'h0000_0000;
    end else if (tick && seq_cnt_r != 32'hFFFF_FFFF) begin
      seq_cnt_r <= seq_cnt_r + 32'h0000_0001;
    end
  end

  // wake sources allowed depend on why the device went down
  always_ff @(posedge clk_i) begin
    if (rtc_clr) begin
      wake_mask_r <= 4'hF;
    end else if (powered && boot_exp_r) begin
      wake_mask_r <= 4'hA;
    end else if (powered && sleep_req) begin
      wake_mask_r <= 4'hE;
    end else if (state_r == S_FAIL) begin
      wake_mask_r <= 4'hF;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs follow the next state so they change with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_request_o <= 1'b0;
      main_supply_enable_o <= 1'b0;
      pll_enable_o <= 1'b0;
      clocks_run_o <= 1'b0;
      cold_init_n_o <= 1'b0;
      core_init_n_o <= 1'b0;
      core_bus_owner_o <= 1'b0;
      reset_vector_fetch_o <= 1'b0;
    end else begin
      supply_request_o <= state_nxt inside {S_WAKE, S_FAIL, S_PASS};
      main_supply_enable_o <= state_nxt inside {S_PASS, S_CONV, S_PLL, S_COLD, S_CORE,
                                                S_RUN, S_SWITCH};
      pll_enable_o <= state_nxt inside {S_PLL, S_COLD, S_CORE, S_RUN};
      clocks_run_o <= state_nxt inside {S_COLD, S_CORE, S_RUN};
      cold_init_n_o <= state_nxt inside {S_CORE, S_RUN};
      core_init_n_o <= state_nxt == S_RUN;
      core_bus_owner_o <= state_nxt inside {S_COLD, S_CORE, S_RUN};
      reset_vector_fetch_o <= state_r == S_CORE && state_nxt == S_RUN;
    end
  end

  // only a deep sleep leaves dram refreshing itself; it holds until the core runs
  always_ff @(posedge clk_i) begin
    if (rtc_clr) begin
      dram_self_refresh_o <= 1'b0;
    end else if (powered && sleep_req) begin
      dram_self_refresh_o <= 1'b1;
    end else if (state_nxt == S_RUN) begin
      dram_self_refresh_o <= 1'b0;
    end
  end

  // core clock output; resets release on its rising edge
  logic [31:0] cdiv_r;
  assign core_edge = clocks_run_o && (cdiv_r == 32'(CORE_DIV / 2 - 1)) && !core_clock_out_o;
  always_ff @(posedge clk_i) begin
    if (rst_i || !clocks_run_o) begin
      cdiv_r <= 32'h0000_0000;
      core_clock_out_o <= 1'b0;
    end else if (cdiv_r == 32'(CORE_DIV / 2 - 1)) begin
      cdiv_r <= 32'h0000_0000;
      core_clock_out_o <= ~core_clock_out_o;
    end else begin
      cdiv_r <= cdiv_r + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // boot timeout timer, armed by the release of rtc init
  logic boot_armed_r;
  logic [31:0] boot_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rtc_clr) begin
      boot_armed_r <= 1'b1;
      boot_cnt_r <= 32'h0000_0000;
      boot_exp_r <= 1'b0;
    end else begin
      if (boot_armed_r && tick) begin
        boot_cnt_r <= boot_cnt_r + 32'h0000_0001;
      end
      if (wr_ctrl && wb_dat_i[CTRL_BOOT_CLR]) begin
        boot_armed_r <= 1'b0;
      end else if (boot_armed_r && done(boot_cnt_r, BOOT_T, tick)) begin
        boot_armed_r <= 1'b0;
        boot_exp_r <= 1'b1;
      end
      if (boot_exp_r && powered) begin
        boot_exp_r <= 1'b0;
      end
    end
  end

  // watchdog; cleared by every system reset so it starts disabled
  logic wd_en_r;
  logic [31:0] wd_period_r;
  logic [31:0] wd_cnt_r;
  assign wd_exp = wd_en_r && tick && (wd_cnt_r >= wd_period_r - 32'h0000_0001);
  always_ff @(posedge clk_i) begin
    if (sys_clr) begin
      wd_en_r <= 1'b0;
      wd_period_r <= WDOG_PERIOD_RST;
    end else begin
      if (wr_ctrl) begin
        wd_en_r <= wb_dat_i[CTRL_WD_EN];
      end
      if (wr && wb_adr_i == ADDR_WDOG) begin
        wd_period_r <= merge(wd_period_r, wb_dat_i, wb_sel_i);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_clr || !wd_en_r || wd_exp || (wr_ctrl && wb_dat_i[CTRL_WD_CLR])) begin
      wd_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
    end
  end

  // reset cause, kept across all but rtc init; write one clears, a new set wins
  logic [4:0] cause_r;
  logic [4:0] cause_set;
  logic [4:0] cause_clr;
  always_comb begin
    cause_set = 5'h00;
    cause_set[CAUSE_SWITCH] = !push_n && state_r != S_SWITCH && state_r != S_RTC_HOLD;
    cause_set[CAUSE_WDOG] = powered && wd_exp;
    cause_set[CAUSE_SLEEP] = powered && sleep_req;
    cause_set[CAUSE_BOOT] = powered && boot_exp_r;
    cause_clr = (wr && wb_adr_i == ADDR_CAUSE && wb_sel_i[0]) ? wb_dat_i[4:0] : 5'h00;
  end
  always_ff @(posedge clk_i) begin
    if (rtc_clr) begin
      cause_r <= 5'h01;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power mode and core status/config images, loaded by every cold reset
  rws_pmode_t pmode_r;
  logic [31:0] cstat_r;
  logic [31:0] ccfg_r;
  assign power_mode_o = pmode_r;
  always_ff @(posedge clk_i) begin
    if (sys_clr) begin
      pmode_r <= PM_FULL;
      cstat_r <= 32'h0000_0000;
      cstat_r[ST_ERL_BIT] <= 1'b1;
      cstat_r[ST_BEV_BIT] <= 1'b1;
      ccfg_r <= {CFG_HI_INIT, 5'h00, CFG_MID_INIT, 3'h0};
      tlb_init_o <= '{random_index: RANDOM_INIT, wired_count: WIRED_INIT};
      core_mode_update_o <= 1'b0;
    end else begin
      if (wr_mode && !sleep_req) begin
        pmode_r <= rws_pmode_t'(wb_dat_i[1:0]);
      end
      if (wr && wb_adr_i == ADDR_CSTAT) begin
        cstat_r <= merge(cstat_r, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == ADDR_CCFG) begin
        ccfg_r <= merge(ccfg_r, wb_dat_i, wb_sel_i);
      end
      core_mode_update_o <= wr_core;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: wb_dat_o <= {29'h0, 1'b0, wd_en_r, boot_armed_r};
        ADDR_WDOG: wb_dat_o <= wd_period_r;
        ADDR_CAUSE: wb_dat_o <= {27'h0, cause_r};
        ADDR_RTC: wb_dat_o <= rtc_cnt_r;
        ADDR_MODE: wb_dat_o <= {30'h0, pmode_r};
        ADDR_CSTAT: wb_dat_o <= cstat_r;
        ADDR_CCFG: wb_dat_o <= ccfg_r;
        ADDR_SEQ: wb_dat_o <= {20'h0, wake_mask_r, dram_self_refresh_o, main_supply_enable_o,
                               pll_enable_o, clocks_run_o, 4'(state_r)};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // rws_sequencer

// ### verification/rws_sequencer_props.sv
// assertion checker for the reset and wake sequencer ports
`timescale 1ns/1ps
module rws_sequencer_props
  import rws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic supply_request_o,
  input wire logic main_supply_enable_o,
  input wire logic pll_enable_o,
  input wire logic clocks_run_o,
  input wire logic cold_init_n_o,
  input wire logic core_init_n_o,
  input wire logic core_bus_owner_o,
  input wire logic reset_vector_fetch_o,
  input wire rws_pmode_t power_mode_o,
  input wire rws_tlb_init_t tlb_init_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cold_first;
    cold_init_n_o && $past(cold_init_n_o);
  endsequence
  sequence s_vec_pulse;
    reset_vector_fetch_o ##1 !reset_vector_fetch_o;
  endsequence
  // check sits on the third rtc tick, so the request lasts well past eight cycles
  a_req_min_hold: assert property ($rose(supply_request_o) |=> supply_request_o [*8])
    else $error("supply request dropped too early");
  a_req_max_hold: assert property ($rose(supply_request_o) |-> ##[1:40] !supply_request_o)
    else $error("supply request never dropped");
  a_fail_no_power: assert property ($fell(supply_request_o) && !main_supply_enable_o |=>
    !main_supply_enable_o [*8]) else $error("main supply raised after failed check");
  a_main_at_check: assert property ($rose(main_supply_enable_o) |-> supply_request_o)
    else $error("main supply rose outside the check");
  a_pll_after_main: assert property ($rose(pll_enable_o) |->
    main_supply_enable_o && $past(main_supply_enable_o, 8)) else $error("pll before converter");
  a_clk_after_pll: assert property ($rose(clocks_run_o) |-> $past(pll_enable_o, 4))
    else $error("clocks before pll settled");
  a_cold_first: assert property ($rose(core_init_n_o) |-> s_cold_first)
    else $error("core init released before cold init");
  a_vector_on_run: assert property ($rose(core_init_n_o) |-> s_vec_pulse)
    else $error("no reset vector fetch pulse");
  a_full_on_run: assert property ($rose(core_init_n_o) |-> power_mode_o == PM_FULL)
    else $error("power mode not full speed after reset");
  a_tlb_cold: assert property ($rose(cold_init_n_o) |-> tlb_init_o == {RANDOM_INIT, WIRED_INIT})
    else $error("tlb init values wrong");
  a_owner_clocks: assert property (core_bus_owner_o == clocks_run_o)
    else $error("bus owner differs from clocks run");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // rws_sequencer_props
bind rws_sequencer rws_sequencer_props u_props (.*);

// ### verification/rws_far_side.sv
// far-side model: rtc init, battery monitor, power button and reset switch
`timescale 1ns/1ps
module rws_far_side #(
  parameter int HOLD_CYC = 40
) (
  input wire logic clk_i,
  input wire logic batt_ok_i,
  output logic rtc_domain_init_n_o,
  output logic push_switch_init_n_o,
  output logic power_button_o,
  output logic battery_inhibit_in_o
);
  // oscillator start-up hold is shortened to HOLD_CYC cycles to keep the run short
  initial begin
    rtc_domain_init_n_o = 1'b0;
    push_switch_init_n_o = 1'b1;
    power_button_o = 1'b0;
    battery_inhibit_in_o = 1'b1;
    repeat (HOLD_CYC) @(posedge clk_i);
    rtc_domain_init_n_o <= 1'b1;
  end
  always @(posedge clk_i) battery_inhibit_in_o <= batt_ok_i;
  task automatic press();
    @(posedge clk_i);
    power_button_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    power_button_o <= 1'b0;
  endtask
  // 5000 cycles of 20 ns give the full 100 us pulse
  task automatic push_switch();
    @(posedge clk_i);
    push_switch_init_n_o <= 1'b0;
    repeat (5000) @(posedge clk_i);
    push_switch_init_n_o <= 1'b1;
  endtask
endmodule // rws_far_side

// ### verification/test_rws_sequencer.sv
// self-checking bench of the reset and wake sequencer
`timescale 1ns/1ps
module test_rws_sequencer;
  import rws_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic card_detect_n_i = 1'b1, alarm_wake_timer_i = 1'b0, batt_ok = 1'b1;
  logic [7:0] gpio_wake_i = 8'h00;
  logic rtc_domain_init_n_i, push_switch_init_n_i, power_button_i, battery_inhibit_in_i;
  logic wb_ack_o, supply_request_o, main_supply_enable_o, pll_enable_o, clocks_run_o;
  logic dram_self_refresh_o, core_clock_out_o, cold_init_n_o, core_init_n_o;
  logic core_bus_owner_o, reset_vector_fetch_o, core_mode_update_o;
  rws_pmode_t power_mode_o;
  rws_tlb_init_t tlb_init_o;
  int n_errors = 0, checked = 0, n_upd = 0;
  logic [31:0] q1, q2;

  rws_sequencer #(.RTC_DIV(4), .CORE_DIV(2), .CONV_T(3), .PLL_T(2), .COLD_T(2), .BOOT_T(50))
    DUT (.*);
  rws_far_side FAR (.clk_i(clk_i), .batt_ok_i(batt_ok),
    .rtc_domain_init_n_o(rtc_domain_init_n_i), .push_switch_init_n_o(push_switch_init_n_i),
    .power_button_o(power_button_i), .battery_inhibit_in_o(battery_inhibit_in_i));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (core_mode_update_o === 1'b1) n_upd <= n_upd + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; a stuck slave ends the run instead of hanging it
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) begin
      chk(32'h0000_0DEA, 32'h0000_0ACC);
      report_and_stop();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, e);
  endtask
  task automatic wait_for(input int sel, input logic lvl);
    int i;
    logic s;
    for (i = 0; i < 12000; i++) begin
      @(posedge clk_i);
      case (sel)
        0: s = core_init_n_o;
        1: s = main_supply_enable_o;
        default: s = supply_request_o;
      endcase
      if (s === lvl) return;
    end
    chk({31'h0, s}, {31'h0, lvl});
    report_and_stop();
  endtask
  task automatic wake(input int src);
    @(posedge clk_i);
    case (src)
      0: gpio_wake_i <= 8'h01;
      1: alarm_wake_timer_i <= 1'b1;
      2: card_detect_n_i <= 1'b0;
      default: FAR.press();
    endcase
    repeat (12) @(posedge clk_i);
    gpio_wake_i <= 8'h00;
    alarm_wake_timer_i <= 1'b0;
    card_detect_n_i <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_first_boot();
    repeat (60) @(posedge clk_i);
    wake(0);
    wait_for(0, 1'b1);
    q1 = core_clock_out_o;
    @(posedge clk_i);
    chk(core_clock_out_o, !q1[0]);
    chk({main_supply_enable_o, pll_enable_o, clocks_run_o, core_bus_owner_o}, 4'hF);
    chk(tlb_init_o, 10'h3E0);
    chk(power_mode_o, PM_FULL);
    rd_chk(ADDR_CSTAT, 32'h0040_0004);
    rd_chk(ADDR_CCFG, 32'h0002_4000);
    rd_chk(ADDR_CAUSE, 32'h0000_0001);
    rd_chk(ADDR_WDOG, WDOG_PERIOD_RST);
    rd_chk(8'h20, 32'h0000_0000);
    wr(ADDR_CAUSE, 32'h0000_001F);
    q1 = n_upd;
    wr(ADDR_CSTAT, 32'h0040_0004);
    repeat (3) @(posedge clk_i);
    chk(n_upd, q1 + 1);
    wr(ADDR_MODE, 32'h0000_0002);
    rd_chk(ADDR_MODE, 32'h0000_0002);
    wr(ADDR_MODE, 32'h0000_0001);
    chk(power_mode_o, PM_STANDBY);
  endtask
  // boot timer left uncleared: shutdown, gpio refused, alarm accepted
  task automatic t_boot_timeout();
    wait_for(0, 1'b0);
    wake(0);
    chk(supply_request_o, 1'b0);
    wake(1);
    wait_for(0, 1'b1);
    rd_chk(ADDR_CAUSE, 32'h0000_0010);
    wr(ADDR_CAUSE, 32'h0000_001F);
  endtask
  task automatic t_watchdog();
    // only byte lane 0 may land: the upper bytes keep the period's reset value
    wb(1'b1, ADDR_WDOG, 32'hFFFF_FF04, 4'h1, q1);
    rd_chk(ADDR_WDOG, 32'h0000_8004);
    wr(ADDR_WDOG, 32'h0000_0004);
    wr(ADDR_CTRL, 32'h0000_0002);
    wait_for(0, 1'b0);
    chk(main_supply_enable_o, 1'b1);
    wait_for(0, 1'b1);
    chk(power_mode_o, PM_FULL);
    rd_chk(ADDR_CAUSE, 32'h0000_0004);
    wr(ADDR_CAUSE, 32'h0000_001F);
  endtask
  task automatic t_switch();
    wb(1'b0, ADDR_RTC, 32'h0000_0000, 4'hF, q1);
    FAR.push_switch();
    wait_for(0, 1'b1);
    wb(1'b0, ADDR_RTC, 32'h0000_0000, 4'hF, q2);
    chk(q2 > q1, 1'b1);
    rd_chk(ADDR_CAUSE, 32'h0000_0002);
    wr(ADDR_CAUSE, 32'h0000_001F);
  endtask
  task automatic t_sleep();
    wr(ADDR_MODE, 32'h0000_0003);
    wait_for(1, 1'b0);
    chk({dram_self_refresh_o, core_init_n_o}, 2'b10);
    batt_ok <= 1'b0;
    wake(2);
    wait_for(2, 1'b1);
    wait_for(2, 1'b0);
    repeat (20) @(posedge clk_i);
    chk(main_supply_enable_o, 1'b0);
    batt_ok <= 1'b1;
    wake(3);
    wait_for(0, 1'b1);
    chk(dram_self_refresh_o, 1'b0);
    rd_chk(ADDR_CAUSE, 32'h0000_0008);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_first_boot();
    t_boot_timeout();
    t_watchdog();
    t_switch();
    t_sleep();
    report_and_stop();
  end
endmodule // test_rws_sequencer
